// >>> hw/lin_wake_pkg.sv
/*
 * Constants, register map and types for the sleep, wake-up and fault
 * controller of a single-wire serial bus node.
 * Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port.
 */
// Notes on behaviour
// - Halt bit stops traffic until next sync break.
// - Checksum or role change mid-frame resets interface.
// - Four seconds idle while awake sets idle flag.
// - Rouse request bit sends a wake-up pulse.
// - Master sets complete and interrupts after wake-up.
// - Slave raises no interrupt after own wake-up.
// - No answer in 150 ms: fault, timeout, interrupt.
// - Detected wake-up sets rouse and complete flags.
// - Any error interrupts and abandons current frame.
// - Fault clear trigger clears detail and fault.
// - Fault set blocks master start and wake-up.
package lin_wake_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned TICK_HZ         = 1_000_000;
	localparam int unsigned CYC_PER_TICK    = CLK_HZ / TICK_HZ;
	localparam int unsigned IDLE_TIMEOUT_S  = 4;
	localparam int unsigned IDLE_TICKS      = IDLE_TIMEOUT_S * TICK_HZ;
	localparam int unsigned RESP_TIMEOUT_MS = 150;
	localparam int unsigned RESP_TICKS      = RESP_TIMEOUT_MS * (TICK_HZ / 1000);
	localparam int unsigned WAKE_TX_US      = 250;
	localparam int unsigned WAKE_TX_TICKS   = WAKE_TX_US * (TICK_HZ / 1_000_000);
	localparam int unsigned WAKE_DET_US     = 150;
	localparam int unsigned WAKE_DET_TICKS  = WAKE_DET_US * (TICK_HZ / 1_000_000);

	////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam int unsigned ADDR_W      = 4;
	localparam logic [3:0]  OFS_CTRL    = 4'h0;
	localparam logic [3:0]  OFS_STATUS  = 4'h4;
	localparam logic [3:0]  OFS_DETAIL  = 4'h8;
	localparam logic [3:0]  OFS_MASK    = 4'hc;

	// Control register fields
	localparam int unsigned CTRL_HALT   = 7;
	localparam int unsigned CTRL_DOZE   = 6;
	localparam int unsigned CTRL_DACK   = 4;
	localparam int unsigned CTRL_CKSUM  = 3;
	localparam int unsigned CTRL_FCLR   = 2;
	localparam int unsigned CTRL_ROUSE  = 1;
	localparam int unsigned CTRL_MASTER = 0;

	// Status and mask register fields
	localparam int unsigned STAT_IDLE   = 6;
	localparam int unsigned STAT_FAULT  = 2;
	localparam int unsigned STAT_ROUSE  = 1;
	localparam int unsigned STAT_DONE   = 0;
	localparam logic [7:0]  STAT_USED   = 8'h47;

	// Fault detail fields: response timeout at bit 2, frame error kinds around it
	localparam int unsigned DET_RESPONSE_TIMEOUT_FLAG    = 2;

	// Reset values
	localparam logic [7:0]  RST_CTRL    = 8'h00;
	localparam logic [7:0]  RST_STATUS  = 8'h00;
	localparam logic [4:0]  RST_DETAIL  = 5'h00;
	localparam logic [7:0]  RST_MASK    = 8'h00;

	// Bus answers
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Wake-up sequencer
	typedef enum logic [1:0] {
		W_IDLE,
		W_SEND,
		W_WAIT
	} wake_state_t;

endpackage

// >>> hw/timer_if.sv
/*
 * Carrier between the controller and one of its tick timers.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface timer_if;
	logic run;
	logic tick;
	logic expired;

	modport user  (output run, output tick, input expired);
	modport timer (input run, input tick, output expired);
endinterface

// >>> hw/tick_timer.sv
/*
 * Tick counter that flags expiry after LIMIT ticks of continuous run.
 * Assumes a one-cycle tick enable and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module tick_timer #(
	parameter int unsigned LIMIT = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	timer_if.timer   tif
);

	typedef struct packed {
		logic [31:0] count;
		logic        expired;
	} timer_state_t;

	timer_state_t st_ff;
	timer_state_t nxt_st;

	// Count while running, hold at the limit, clear when stopped
	always_comb begin
		nxt_st = st_ff;
		if (!tif.run) begin
			nxt_st.count = 32'h0;
		end else if (tif.tick && st_ff.count != 32'(LIMIT)) begin
			nxt_st.count = st_ff.count + 32'h1;
		end
		nxt_st.expired = tif.run && (nxt_st.count == 32'(LIMIT));
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tif.expired = st_ff.expired;

endmodule // tick_timer

// >>> hw/lin_wake_ctrl.sv
/*
 * Sleep, wake-up and fault handling of a single-wire bus node, with an
 * AXI4-Lite register port and one level interrupt.
 * Assumes a frame engine on the same clock supplies busy, break and error
 * strobes, and that bus_rx comes from a pin in another clock domain.
 */
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module lin_wake_ctrl #(
	parameter int unsigned IDLE_TICKS = lin_wake_pkg::IDLE_TICKS,
	parameter int unsigned RESP_TICKS = lin_wake_pkg::RESP_TICKS
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Bus pins
	input  wire logic        bus_rx,
	output logic             bus_tx,
	// Frame engine side
	input  wire logic        frame_busy,
	input  wire logic        sync_break,
	input  wire logic [3:0]  frame_err,
	output logic             frame_halted,
	output logic             data_ack,
	output logic             iface_reset,
	output logic             frame_abort,
	output logic             master_start_ok,
	output logic             role_master,
	output logic             cksum_sel,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [2:0]               rx_sync;
		logic                     rx_lvl;
		logic                     halted;
		logic                     doze;
		logic                     cksum;
		logic                     master;
		logic [7:0]               status;
		logic [4:0]               detail;
		logic [7:0]               mask;
		lin_wake_pkg::wake_state_t wstate;
		logic                     idle_hit;
		logic                     det_hit;
		logic [6:0]               div;
		logic                     tick;
		logic                     tx;
		logic                     dack_p;
		logic                     rst_p;
		logic                     abort_p;
		logic                     aw_ok;
		logic [3:0]               aw_addr;
		logic                     w_ok;
		logic [7:0]               w_data;
		logic                     w_lane0;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [7:0]               rdata;
		logic [1:0]               rresp;
	} ctrl_state_t;

	ctrl_state_t st_ff;
	ctrl_state_t nxt_st;

	timer_if idle_t ();
	timer_if resp_t ();
	timer_if wtx_t ();
	timer_if wdet_t ();

	////////////////////////////////////////////////////////////////////////////
	// Timers
	tick_timer #(.LIMIT(IDLE_TICKS)) u_idle (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tif     (idle_t.timer)
	);
	tick_timer #(.LIMIT(RESP_TICKS)) u_resp (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tif     (resp_t.timer)
	);
	tick_timer #(.LIMIT(lin_wake_pkg::WAKE_TX_TICKS)) u_wtx (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tif     (wtx_t.timer)
	);
	tick_timer #(.LIMIT(lin_wake_pkg::WAKE_DET_TICKS)) u_wdet (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tif     (wdet_t.timer)
	);

	// Timer run conditions and shared tick
	assign idle_t.tick = st_ff.tick;
	assign resp_t.tick = st_ff.tick;
	assign wtx_t.tick  = st_ff.tick;
	assign wdet_t.tick = st_ff.tick;
	assign idle_t.run  = !st_ff.doze && st_ff.rx_lvl && !st_ff.idle_hit;
	assign resp_t.run  = (st_ff.wstate == lin_wake_pkg::W_WAIT);
	assign wtx_t.run   = (st_ff.wstate == lin_wake_pkg::W_SEND);
	assign wdet_t.run  = (st_ff.wstate == lin_wake_pkg::W_IDLE) && !st_ff.rx_lvl
		&& !st_ff.det_hit && (st_ff.doze || st_ff.idle_hit);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	logic       wr_fire;
	logic       wr_ctrl;
	logic       wr_stat;
	logic       wr_mask;
	logic       rx_fall;
	logic       fclr;
	logic [7:0] stat_set;
	logic [7:0] stat_clr;
	logic       do_halt;
	logic       do_rouse;

	always_comb begin
		nxt_st   = st_ff;
		stat_set = 8'h00;
		stat_clr = 8'h00;
		fclr     = 1'b0;
		do_halt  = 1'b0;
		do_rouse = 1'b0;

		// Pin synchroniser; level accepted when last two stages agree
		nxt_st.rx_sync = {st_ff.rx_sync[1:0], bus_rx};
		if (st_ff.rx_sync[1] == st_ff.rx_sync[2]) begin
			nxt_st.rx_lvl = st_ff.rx_sync[2];
		end
		rx_fall = st_ff.rx_lvl && !nxt_st.rx_lvl;

		// Microsecond tick divider
		nxt_st.tick = 1'b0;
		if (st_ff.div == 7'(lin_wake_pkg::CYC_PER_TICK - 1)) begin
			nxt_st.div  = 7'h0;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.div = st_ff.div + 7'h1;
		end

		// One-cycle strobes
		nxt_st.dack_p  = 1'b0;
		nxt_st.rst_p   = 1'b0;
		nxt_st.abort_p = 1'b0;

		// Write channel capture, either order
		if (awvalid && !st_ff.aw_ok) begin
			nxt_st.aw_ok   = 1'b1;
			nxt_st.aw_addr = awaddr;
		end
		if (wvalid && !st_ff.w_ok) begin
			nxt_st.w_ok    = 1'b1;
			nxt_st.w_data  = wdata[7:0];
			nxt_st.w_lane0 = wstrb[0];
		end
		if (st_ff.bvalid && bready) begin
			nxt_st.bvalid = 1'b0;
		end
		wr_fire = st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid;
		wr_ctrl = wr_fire && st_ff.w_lane0 && (st_ff.aw_addr == lin_wake_pkg::OFS_CTRL);
		wr_stat = wr_fire && st_ff.w_lane0 && (st_ff.aw_addr == lin_wake_pkg::OFS_STATUS);
		wr_mask = wr_fire && st_ff.w_lane0 && (st_ff.aw_addr == lin_wake_pkg::OFS_MASK);
		if (wr_fire) begin
			nxt_st.aw_ok  = 1'b0;
			nxt_st.w_ok   = 1'b0;
			nxt_st.bvalid = 1'b1;
			case (st_ff.aw_addr)
				lin_wake_pkg::OFS_CTRL,
				lin_wake_pkg::OFS_STATUS,
				lin_wake_pkg::OFS_DETAIL,
				lin_wake_pkg::OFS_MASK: nxt_st.bresp = lin_wake_pkg::RESP_OKAY;
				default: nxt_st.bresp = lin_wake_pkg::RESP_SLVERR;
			endcase
		end

		// Control register write effects
		if (wr_ctrl) begin
			nxt_st.doze = st_ff.w_data[lin_wake_pkg::CTRL_DOZE];
			do_halt  = st_ff.w_data[lin_wake_pkg::CTRL_HALT];
			do_rouse = st_ff.w_data[lin_wake_pkg::CTRL_ROUSE];
			fclr     = st_ff.w_data[lin_wake_pkg::CTRL_FCLR];
			nxt_st.dack_p = st_ff.w_data[lin_wake_pkg::CTRL_DACK] && !do_halt;
			nxt_st.cksum  = st_ff.w_data[lin_wake_pkg::CTRL_CKSUM];
			nxt_st.master = st_ff.w_data[lin_wake_pkg::CTRL_MASTER];
			if (frame_busy && (nxt_st.cksum != st_ff.cksum
				|| nxt_st.master != st_ff.master)) begin
				nxt_st.rst_p = 1'b1;
			end
		end
		if (wr_stat) begin
			stat_clr = st_ff.w_data & lin_wake_pkg::STAT_USED;
		end
		if (wr_mask) begin
			nxt_st.mask = st_ff.w_data & lin_wake_pkg::STAT_USED;
		end

		// Frame halt held until the next sync break
		if (do_halt) begin
			nxt_st.halted = 1'b1;
		end else if (sync_break) begin
			nxt_st.halted = 1'b0;
		end

		// Bus idle timeout
		if (rx_fall) begin
			nxt_st.idle_hit = 1'b0;
		end else if (idle_t.expired && !st_ff.idle_hit) begin
			nxt_st.idle_hit = 1'b1;
			stat_set[lin_wake_pkg::STAT_IDLE] = 1'b1;
		end

		// Wake-up detection from another node
		if (st_ff.rx_lvl) begin
			nxt_st.det_hit = 1'b0;
		end else if (wdet_t.expired && !st_ff.det_hit) begin
			nxt_st.det_hit = 1'b1;
			stat_set[lin_wake_pkg::STAT_ROUSE] = 1'b1;
			stat_set[lin_wake_pkg::STAT_DONE]  = 1'b1;
		end

		// Wake-up sequencer
		case (st_ff.wstate)
			lin_wake_pkg::W_IDLE: begin
				if (do_rouse && !st_ff.status[lin_wake_pkg::STAT_FAULT]) begin
					nxt_st.wstate = lin_wake_pkg::W_SEND;
				end
			end
			lin_wake_pkg::W_SEND: begin
				if (wtx_t.expired) begin
					if (st_ff.master) begin
						nxt_st.wstate = lin_wake_pkg::W_IDLE;
						stat_set[lin_wake_pkg::STAT_DONE] = 1'b1;
					end else begin
						nxt_st.wstate = lin_wake_pkg::W_WAIT;
					end
				end
			end
			lin_wake_pkg::W_WAIT: begin
				if (rx_fall) begin
					nxt_st.wstate = lin_wake_pkg::W_IDLE;
				end else if (resp_t.expired) begin
					nxt_st.wstate = lin_wake_pkg::W_IDLE;
					stat_set[lin_wake_pkg::STAT_FAULT] = 1'b1;
					nxt_st.detail[lin_wake_pkg::DET_RESPONSE_TIMEOUT_FLAG] = 1'b1;
				end
			end
			default: nxt_st.wstate = lin_wake_pkg::W_IDLE;
		endcase
		nxt_st.tx = (nxt_st.wstate != lin_wake_pkg::W_SEND);

		// Frame errors abandon the frame and raise the fault
		if (fclr) begin
			nxt_st.detail = lin_wake_pkg::RST_DETAIL;
			stat_clr[lin_wake_pkg::STAT_FAULT] = 1'b1;
		end
		if (|frame_err) begin
			nxt_st.detail = nxt_st.detail | {frame_err[3:2], 1'b0, frame_err[1:0]}; // Skip timeout bit
			stat_set[lin_wake_pkg::STAT_FAULT] = 1'b1;
			nxt_st.abort_p = 1'b1;
		end
		if (stat_set[lin_wake_pkg::STAT_FAULT] && resp_t.expired) begin
			nxt_st.detail[lin_wake_pkg::DET_RESPONSE_TIMEOUT_FLAG] = 1'b1;
		end

		// Sticky flags: set wins over software clear
		nxt_st.status = (st_ff.status & ~stat_clr) | stat_set;

		// Read channel
		if (st_ff.rvalid && rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (arvalid && !st_ff.rvalid) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = lin_wake_pkg::RESP_OKAY;
			case (araddr)
				lin_wake_pkg::OFS_CTRL: nxt_st.rdata = {st_ff.halted, st_ff.doze, 1'b0,
					1'b0, st_ff.cksum, 1'b0, (st_ff.wstate != lin_wake_pkg::W_IDLE),
					st_ff.master};
				lin_wake_pkg::OFS_STATUS: nxt_st.rdata = st_ff.status;
				lin_wake_pkg::OFS_DETAIL: nxt_st.rdata = {3'h0, st_ff.detail};
				lin_wake_pkg::OFS_MASK:   nxt_st.rdata = st_ff.mask;
				default: begin
					nxt_st.rdata = 8'h00;
					nxt_st.rresp = lin_wake_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff         <= '0;
			st_ff.rx_sync <= 3'h7;
			st_ff.rx_lvl  <= 1'b1;
			st_ff.tx      <= 1'b1;
			st_ff.status  <= lin_wake_pkg::RST_STATUS;
			st_ff.mask    <= lin_wake_pkg::RST_MASK;
			st_ff.wstate  <= lin_wake_pkg::W_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign awready         = !st_ff.aw_ok;
	assign wready          = !st_ff.w_ok;
	assign bvalid          = st_ff.bvalid;
	assign bresp           = st_ff.bresp;
	assign arready         = !st_ff.rvalid;
	assign rvalid          = st_ff.rvalid;
	assign rresp           = st_ff.rresp;
	assign rdata           = {24'h0, st_ff.rdata};
	assign bus_tx          = st_ff.tx;
	assign frame_halted    = st_ff.halted;
	assign data_ack        = st_ff.dack_p;
	assign iface_reset     = st_ff.rst_p;
	assign frame_abort     = st_ff.abort_p;
	assign role_master     = st_ff.master;
	assign cksum_sel       = st_ff.cksum;
	assign master_start_ok = st_ff.master && !st_ff.halted
		&& !st_ff.status[lin_wake_pkg::STAT_FAULT];
	assign irq             = |(st_ff.status & st_ff.mask);

endmodule // lin_wake_ctrl

// >>> verif/lin_wake_checker.sv
/* Port assertions for the sleep, wake-up and fault controller.
   Assumes it is bound into the controller and shares its clock and reset. */
`timescale 1ns/1ps
module lin_wake_checker #(
	parameter int unsigned IDLE_TICKS = 1,
	parameter int unsigned RESP_TICKS = 1
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       awvalid,
	input wire logic       awready,
	input wire logic       wvalid,
	input wire logic       wready,
	input wire logic       bvalid,
	input wire logic       bus_tx,
	input wire logic       frame_busy,
	input wire logic       sync_break,
	input wire logic [3:0] frame_err,
	input wire logic       frame_halted,
	input wire logic       iface_reset,
	input wire logic       frame_abort,
	input wire logic       master_start_ok,
	input wire logic       role_master
);
	logic [15:0] low_ff;
	logic [15:0] nxt_low;

	// Length of the running low stretch on the bus drive
	always_comb nxt_low = bus_tx ? 16'h0 : low_ff + 16'h1;
	always_ff @(posedge aclk) low_ff <= aresetn ? nxt_low : 16'h0;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////
	// Sequences
	sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
	sequence s_resp_2; !bvalid ##1 bvalid; endsequence
	sequence s_err; frame_err != 4'h0; endsequence

	////////////////////////////////////////////////////////////////////////
	// Properties
	property p_wr_resp; s_wr_take |=> s_resp_2; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_abort; s_err |=> frame_abort; endproperty
	a_abort: assert property (p_abort) else $error("frame not dropped");
	property p_abort_cause; frame_abort |-> $past(frame_err) != 4'h0; endproperty
	a_abort_cause: assert property (p_abort_cause) else $error("stray abort");
	property p_err_block; s_err |=> !master_start_ok; endproperty
	a_err_block: assert property (p_err_block) else $error("start after fault");
	property p_halt_block; frame_halted |-> !master_start_ok; endproperty
	a_halt_block: assert property (p_halt_block) else $error("start while halted");
	property p_halt_clr; sync_break |=> !frame_halted; endproperty
	a_halt_clr: assert property (p_halt_clr) else $error("halt kept");
	property p_ifr_cause;
		iface_reset |-> $past(frame_busy) || $past(frame_busy, 2);
	endproperty
	a_ifr_cause: assert property (p_ifr_cause) else $error("reset when idle");
	property p_fault_hold;
		role_master && !frame_halted && !master_start_ok && awready && !awvalid
			|=> !master_start_ok;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault lost");
	property p_tx_len; $rose(bus_tx) |-> low_ff > 16'd24800 && low_ff < 16'd25200; endproperty
	a_tx_len: assert property (p_tx_len) else $error("wake pulse length");
endmodule // lin_wake_checker

// >>> verif/bus_node_model.sv
/* Behavioural model of another node on the single-wire bus.
   Assumes a pull-up: the line is low while either node drives it. */
`timescale 1ns/1ps
module bus_node_model (
	input  wire logic aclk,
	input  wire logic bus_tx,
	input  wire logic wake_cmd,
	input  wire logic answer_en,
	output logic      bus_rx
);
	logic [15:0] drv_ff = 16'h0;
	logic [15:0] dly_ff = 16'h0;
	logic        tx_ff  = 1'b1;

	// Wake pulse of 250 us on command, 1 us header break 2 us after a wake ends
	always_ff @(posedge aclk) begin
		tx_ff <= bus_tx;
		if (wake_cmd)
			drv_ff <= 16'd25000;
		else if (dly_ff == 16'h1)
			drv_ff <= 16'd100;
		else if (drv_ff != 16'h0)
			drv_ff <= drv_ff - 16'h1;
		if (answer_en && bus_tx && !tx_ff)
			dly_ff <= 16'd200;
		else if (dly_ff != 16'h0)
			dly_ff <= dly_ff - 16'h1;
	end

	// Wired-and line
	assign bus_rx = bus_tx & (drv_ff == 16'h0);
endmodule // bus_node_model

// >>> verif/test_lin_wake_ctrl.sv
/* Self-checking bench for the sleep, wake-up and fault controller.
   Assumes the bus node model on the line and short idle and reply timers. */
`timescale 1ns/1ps
module test_lin_wake_ctrl;
	localparam logic [3:0] a_ctl = lin_wake_pkg::OFS_CTRL;
	localparam logic [3:0] a_sta = lin_wake_pkg::OFS_STATUS;
	localparam logic [3:0] a_det = lin_wake_pkg::OFS_DETAIL;
	localparam logic [1:0] ok_r  = lin_wake_pkg::RESP_OKAY;
	logic        aclk = 1'b0, aresetn = 1'b0, frame_busy = 1'b0, sync_break = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        wake_cmd = 1'b0, answer_en = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, frame_err = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        awready, wready, bvalid, arready, rvalid, bus_rx, bus_tx, frame_halted;
	logic        data_ack, iface_reset, frame_abort, master_start_ok, role_master, cksum_sel, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          err_count = 0, total_checks = 0, n_ifr = 0, n_ack = 0, n = 0;

	lin_wake_ctrl #(.IDLE_TICKS(20), .RESP_TICKS(10)) u_dut (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .bus_rx, .bus_tx, .frame_busy, .sync_break, .frame_err, .frame_halted,
		.data_ack, .iface_reset, .frame_abort, .master_start_ok, .role_master, .cksum_sel, .irq
	);
	bus_node_model u_node (.aclk, .bus_tx, .wake_cmd, .answer_en, .bus_rx);

	// 100 MHz clock
	always #5 aclk = ~aclk;

	// Pulse counters
	always @(posedge aclk) begin
		if (iface_reset) n_ifr++;
		if (data_ack) n_ack++;
	end

	////////////////////////////////////////////////////////////////////////
	// Compare and bus tasks
	task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t flag %b expected %b", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk_v({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk_v(rdata, {24'h0, e});
		chk_v({30'h0, rresp}, {30'h0, er});
	endtask
	task automatic wt(input logic lv);
		n = 0;
		while (bus_tx !== lv && n < 30000) begin
			@(posedge aclk);
			n++;
		end
		chk_b(bus_tx, lv);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (100000) @(posedge aclk);
		err_count++;
		$display("[FAIL] %0t timeout", $time);
		final_report;
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++) rd(4'(i * 4), 8'h00, ok_r);
		rd(4'h2, 8'h00, lin_wake_pkg::RESP_SLVERR);
		wr(4'h6, 8'hff, lin_wake_pkg::RESP_SLVERR);
		wr(lin_wake_pkg::OFS_MASK, 8'h47, ok_r);
		repeat (2200) @(posedge aclk);
		rd(a_sta, 8'h40, ok_r);
		chk_b(irq, 1'b1);
		repeat (500) @(posedge aclk);
		rd(a_sta, 8'h40, ok_r);
		wr(a_sta, 8'h40, ok_r);
		wr(a_ctl, 8'h01, ok_r);
		chk_b(role_master, 1'b1);
		chk_b(master_start_ok, 1'b1);
		@(posedge aclk);
		frame_err <= 4'h5;
		@(posedge aclk);
		frame_err <= 4'h0;
		rd(a_det, 8'h09, ok_r);
		rd(a_sta, 8'h04, ok_r);
		chk_b(irq, 1'b1);
		wr(a_ctl, 8'h03, ok_r);
		repeat (50) @(posedge aclk);
		chk_b(bus_tx, 1'b1);
		chk_b(master_start_ok, 1'b0);
		wr(a_ctl, 8'h05, ok_r);
		rd(a_det, 8'h00, ok_r);
		rd(a_sta, 8'h00, ok_r);
		chk_b(irq, 1'b0);
		wr(a_ctl, 8'h11, ok_r);
		wr(a_ctl, 8'h91, ok_r);
		chk_v(32'(n_ack), 32'h1);
		chk_b(frame_halted, 1'b1);
		sync_break <= 1'b1;
		@(posedge aclk);
		sync_break <= 1'b0;
		@(posedge aclk);
		chk_b(frame_halted, 1'b0);
		frame_busy <= 1'b1;
		wr(a_ctl, 8'h09, ok_r);
		chk_b(cksum_sel, 1'b1);
		frame_busy <= 1'b0;
		wr(a_ctl, 8'h01, ok_r);
		chk_v(32'(n_ifr), 32'h1);
		// Master wake-up
		answer_en <= 1'b1;
		wr(a_ctl, 8'h03, ok_r);
		wt(1'b0);
		wt(1'b1);
		chk_b(n > 24700 && n < 25300, 1'b1);
		repeat (10) @(posedge aclk);
		rd(a_sta, 8'h01, ok_r);
		chk_b(irq, 1'b1);
		wr(a_sta, 8'h47, ok_r);
		// Slave wake-up, first answered by the other node, then left unanswered
		for (int k = 0; k < 2; k++) begin
			wr(a_ctl, 8'h02, ok_r);
			wt(1'b0);
			wt(1'b1);
			repeat (10) @(posedge aclk);
			chk_b(irq, 1'b0);
			rd(a_sta, 8'h00, ok_r);
			answer_en <= 1'b0;
			repeat (1200) @(posedge aclk);
			if (k == 0) rd(a_sta, 8'h00, ok_r);
		end
		rd(a_sta, 8'h04, ok_r);
		rd(a_det, 8'h04, ok_r);
		chk_b(irq, 1'b1);
		wr(a_sta, 8'h47, ok_r);
		wr(a_ctl, 8'h04, ok_r);
		rd(a_det, 8'h00, ok_r);
		// Wake-up from the other node while dozing
		wr(a_ctl, 8'h40, ok_r);
		wr(a_sta, 8'h47, ok_r);
		wake_cmd <= 1'b1;
		@(posedge aclk);
		wake_cmd <= 1'b0;
		repeat (15300) @(posedge aclk);
		rd(a_sta, 8'h03, ok_r);
		chk_b(irq, 1'b1);
		wr(a_ctl, 8'h00, ok_r);
		rd(a_ctl, 8'h00, ok_r);
		final_report;
	end
endmodule // test_lin_wake_ctrl

bind lin_wake_ctrl lin_wake_checker #(.IDLE_TICKS(IDLE_TICKS), .RESP_TICKS(RESP_TICKS)) u_chk (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bus_tx, .frame_busy,
	.sync_break, .frame_err, .frame_halted, .iface_reset, .frame_abort, .master_start_ok,
	.role_master
);
